/* rtl/ssp_ctrl_pkg.sv */
// shared constants for the serial port control-one block
package ssp_ctrl_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
    localparam logic [3:0] ADDR_BUFFER      = 4'h4;
    localparam logic [3:0] ADDR_STATUS      = 4'h8;
    localparam logic [3:0] ADDR_AUX_CONTROL = 4'hc;
    localparam int         ADDR_W           = 4;
    localparam int         DATA_W           = 32;

    // control-one field positions
    localparam int BIT_WRITE_COLLISION = 7;
    localparam int BIT_OVERFLOW        = 6;
    localparam int BIT_ENABLE          = 5;
    localparam int BIT_CLOCK_CTRL      = 4;
    localparam int MODE_LSB            = 0;
    localparam int MODE_W              = 4;

    // status and aux field positions
    localparam int BIT_BUFFER_FULL = 0;
    localparam int BIT_TX_PENDING  = 1;
    localparam int BIT_LINK_ON     = 2;
    localparam int BIT_I2C_TX_DIR  = 0;

    // reset values
    localparam logic [7:0] RESET_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RESET_BUFFER      = 8'h00;
    localparam logic       RESET_AUX_DIR     = 1'b0;

    // pin lanes
    localparam int PIN_CLOCK  = 0;
    localparam int PIN_DOUT   = 1;
    localparam int PIN_DIN    = 2;
    localparam int PIN_SELECT = 3;
    localparam int PIN_N      = 4;

    // link byte framing
    localparam int         BYTE_W       = 8;
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;

    // port_mode_select classes
    typedef enum logic [2:0] {
        MODE_SPI_MASTER = 3'b000,
        MODE_SPI_SLAVE  = 3'b001,
        MODE_I2C_SLAVE  = 3'b010,
        MODE_I2C_MASTER = 3'b011,
        MODE_RESERVED   = 3'b100
    } mode_class_t;

    localparam logic [3:0] SEL_SPI_MASTER_DIV4   = 4'h0;
    localparam logic [3:0] SEL_SPI_MASTER_DIV16  = 4'h1;
    localparam logic [3:0] SEL_SPI_MASTER_DIV64  = 4'h2;
    localparam logic [3:0] SEL_SPI_MASTER_TIMER  = 4'h3;
    localparam logic [3:0] SEL_SPI_SLAVE_SELECT  = 4'h4;
    localparam logic [3:0] SEL_SPI_SLAVE_NOSEL   = 4'h5;
    localparam logic [3:0] SEL_I2C_SLAVE_7BIT    = 4'h6;
    localparam logic [3:0] SEL_I2C_SLAVE_10BIT   = 4'h7;
    localparam logic [3:0] SEL_I2C_MASTER        = 4'h8;
    localparam logic [3:0] SEL_SPI_MASTER_BAUD   = 4'ha;
    localparam logic [3:0] SEL_I2C_MASTER_FW     = 4'hb;
endpackage : ssp_ctrl_pkg

/* rtl/ssp_ctrl_one.sv */
// control-one register, receive path flags and pin takeover of the serial port
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module ssp_ctrl_one
    import ssp_ctrl_pkg::*;
(
    // system clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    // avalon-mm slave
    input  wire logic [ssp_ctrl_pkg::ADDR_W-1:0] address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [ssp_ctrl_pkg::DATA_W-1:0] writedata,
    output logic      [ssp_ctrl_pkg::DATA_W-1:0] readdata,
    output logic                            waitrequest,
    // link side, clocked by the far party
    input  wire logic                       linkClk,
    input  wire logic                       linkSelN,
    input  wire logic                       linkData,
    // serial pins: clock, data out, data in, select
    input  wire logic [ssp_ctrl_pkg::PIN_N-1:0] pinIn,
    output logic      [ssp_ctrl_pkg::PIN_N-1:0] pinOut,
    output logic      [ssp_ctrl_pkg::PIN_N-1:0] pinOe,
    // general purpose port logic sharing the pins
    input  wire logic [ssp_ctrl_pkg::PIN_N-1:0] gpioOut,
    input  wire logic [ssp_ctrl_pkg::PIN_N-1:0] gpioOe,
    output logic      [ssp_ctrl_pkg::PIN_N-1:0] gpioIn
);
    import ssp_ctrl_pkg::*;

    // decode of port_mode_select into a mode class
    function automatic mode_class_t classify(input logic [MODE_W-1:0] sel);
        mode_class_t c;
        c = MODE_RESERVED;
        if (sel == SEL_SPI_MASTER_DIV4 || sel == SEL_SPI_MASTER_DIV16 ||
            sel == SEL_SPI_MASTER_DIV64 || sel == SEL_SPI_MASTER_TIMER ||
            sel == SEL_SPI_MASTER_BAUD) begin
            c = MODE_SPI_MASTER;
        end else if (sel == SEL_SPI_SLAVE_SELECT || sel == SEL_SPI_SLAVE_NOSEL) begin
            c = MODE_SPI_SLAVE;
        end else if (sel == SEL_I2C_SLAVE_7BIT || sel == SEL_I2C_SLAVE_10BIT) begin
            c = MODE_I2C_SLAVE;
        end else if (sel == SEL_I2C_MASTER || sel == SEL_I2C_MASTER_FW) begin
            c = MODE_I2C_MASTER;
        end
        return c;
    endfunction : classify

    // ---------------- link clock domain ----------------
    logic [2:0]        linkBitCount;
    logic [BYTE_W-1:0] linkShift;
    logic [BYTE_W-1:0] linkByte;
    logic              linkDoneToggle;

    // bit counter; deselect clears a partial byte since the clock may stop
    always_ff @(posedge linkClk or negedge rst_b or posedge linkSelN) begin
        if (!rst_b) begin
            linkBitCount <= 3'h0;
        end else if (linkSelN) begin
            linkBitCount <= 3'h0;
        end else begin
            linkBitCount <= linkBitCount + 3'h1;
        end
    end

    // serial shift register, msb first
    always_ff @(posedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            linkShift <= '0;
        end else if (!linkSelN) begin
            linkShift <= {linkShift[BYTE_W-2:0], linkData};
        end
    end

    // completed byte held for the core while it sees the toggle
    always_ff @(posedge linkClk or negedge rst_b) begin
        if (!rst_b) begin
            linkByte       <= '0;
            linkDoneToggle <= 1'b0;
        end else if (!linkSelN && linkBitCount == LAST_BIT_IDX) begin
            linkByte       <= {linkShift[BYTE_W-2:0], linkData};
            linkDoneToggle <= ~linkDoneToggle;
        end
    end

    // ---------------- core clock domain ----------------
    logic                 doneMeta;
    logic                 doneSync;
    logic                 doneSeen;
    logic                 byteDone;
    logic [PIN_N-1:0]     pinMeta;
    logic [PIN_N-1:0]     pinSync;

    // toggle crossing; linkByte is stable until the eighth link edge after it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            doneMeta <= 1'b0;
            doneSync <= 1'b0;
            doneSeen <= 1'b0;
        end else begin
            doneMeta <= linkDoneToggle;
            doneSync <= doneMeta;
            doneSeen <= doneSync;
        end
    end
    assign byteDone = doneSync ^ doneSeen;

    // pin inputs double-synchronised before use
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    // register state
    logic              writeCollision;
    logic              receiveOverflowFlag;
    logic              portEnableBit;
    logic              clockCtrl;
    logic [MODE_W-1:0] portModeSelect;
    logic [BYTE_W-1:0] serialBufferRegister;
    logic              bufferFull;
    logic              txPending;
    logic              i2cTxDir;
    mode_class_t       modeClass;
    logic              busWrite;
    logic              busRead;
    logic              ctrlWrite;
    logic              bufWrite;
    logic              bufRead;
    logic              isMaster;
    logic              overflowEvent;
    logic              collisionEvent;

    // bus qualifiers: an access lands only at the edge waitrequest is low
    assign modeClass = classify(portModeSelect);
    assign isMaster  = (modeClass == MODE_SPI_MASTER) || (modeClass == MODE_I2C_MASTER);
    assign busWrite  = write && !waitrequest;
    assign busRead   = read && !waitrequest;
    assign ctrlWrite = busWrite && address == ADDR_CONTROL_ONE;
    assign bufWrite  = busWrite && address == ADDR_BUFFER;
    assign bufRead   = busRead && address == ADDR_BUFFER;

    // overflow only as SPI slave or I2C receiving slave
    assign overflowEvent = portEnableBit && byteDone && bufferFull && !bufRead &&
                           (modeClass == MODE_SPI_SLAVE ||
                            (modeClass == MODE_I2C_SLAVE && !i2cTxDir));
    // a master-mode buffer write before the last one went out, or while the port is disabled
    assign collisionEvent = bufWrite && isMaster && (txPending || !portEnableBit);

    // one wait state per access
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
        end
    end

    // read data prepared while waitrequest drops; unmapped reads zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= '0;
        end else if (read && waitrequest) begin
            if (address == ADDR_CONTROL_ONE) begin
                readdata <= {24'h000000, writeCollision, receiveOverflowFlag, portEnableBit,
                             clockCtrl, portModeSelect};
            end else if (address == ADDR_BUFFER) begin
                readdata <= {24'h000000, serialBufferRegister};
            end else if (address == ADDR_STATUS) begin
                readdata <= {29'h00000000, portEnableBit, txPending, bufferFull};
            end else if (address == ADDR_AUX_CONTROL) begin
                readdata <= {31'h00000000, i2cTxDir};
            end else begin
                readdata <= '0;
            end
        end
    end

    // software-owned control bits
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            portEnableBit  <= RESET_CONTROL_ONE[BIT_ENABLE];
            clockCtrl      <= RESET_CONTROL_ONE[BIT_CLOCK_CTRL];
            portModeSelect <= RESET_CONTROL_ONE[MODE_LSB +: MODE_W];
            i2cTxDir       <= RESET_AUX_DIR;
        end else begin
            if (ctrlWrite) begin
                portEnableBit  <= writedata[BIT_ENABLE];
                clockCtrl      <= writedata[BIT_CLOCK_CTRL];
                portModeSelect <= writedata[MODE_LSB +: MODE_W];
            end
            if (busWrite && address == ADDR_AUX_CONTROL) begin
                i2cTxDir <= writedata[BIT_I2C_TX_DIR];
            end
        end
    end

    // sticky overflow: hardware only sets, a written zero clears, set wins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            receiveOverflowFlag <= RESET_CONTROL_ONE[BIT_OVERFLOW];
        end else if (overflowEvent) begin
            receiveOverflowFlag <= 1'b1;
        end else if (ctrlWrite && !writedata[BIT_OVERFLOW]) begin
            receiveOverflowFlag <= 1'b0;
        end
    end

    // sticky collision flag, same set-over-clear policy
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            writeCollision <= RESET_CONTROL_ONE[BIT_WRITE_COLLISION];
        end else if (collisionEvent) begin
            writeCollision <= 1'b1;
        end else if (ctrlWrite && !writedata[BIT_WRITE_COLLISION]) begin
            writeCollision <= 1'b0;
        end
    end

    // buffer: on overflow the new byte is dropped, old unread byte kept
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            serialBufferRegister <= RESET_BUFFER;
            bufferFull           <= 1'b0;
        end else begin
            if (portEnableBit && byteDone && (!bufferFull || bufRead)) begin
                serialBufferRegister <= linkByte;
                bufferFull           <= 1'b1;
            end else if (bufWrite && !collisionEvent) begin
                serialBufferRegister <= writedata[BYTE_W-1:0];
            end else if (bufRead) begin
                bufferFull <= 1'b0;
            end
        end
    end

    // master transmit pending from buffer write until a byte completes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            txPending <= 1'b0;
        end else if (!portEnableBit || !isMaster) begin
            txPending <= 1'b0;
        end else if (bufWrite && !collisionEvent) begin
            txPending <= 1'b1;
        end else if (byteDone) begin
            txPending <= 1'b0;
        end
    end

    // pin ownership; directions beyond these are the software's duty
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pinOut <= '0;
            pinOe  <= '0;
            gpioIn <= '0;
        end else begin
            gpioIn <= pinSync;
            if (!portEnableBit) begin
                pinOut <= gpioOut;
                pinOe  <= gpioOe;
            end else if (modeClass == MODE_SPI_MASTER || modeClass == MODE_SPI_SLAVE) begin
                pinOut             <= '0;
                pinOe              <= '0;
                pinOut[PIN_CLOCK]  <= clockCtrl;
                pinOe[PIN_CLOCK]   <= (modeClass == MODE_SPI_MASTER);
                pinOut[PIN_DOUT]   <= serialBufferRegister[BYTE_W-1];
                pinOe[PIN_DOUT]    <= (modeClass == MODE_SPI_MASTER) || !pinSync[PIN_SELECT];
            end else if (modeClass == MODE_I2C_SLAVE || modeClass == MODE_I2C_MASTER) begin
                pinOut <= '0;
                pinOe  <= '0;
                // open drain SCL: drive low only to stretch
                pinOe[PIN_CLOCK] <= (modeClass == MODE_I2C_SLAVE) && !clockCtrl;
            end else begin
                pinOut <= '0;
                pinOe  <= '0;
            end
        end
    end
endmodule : ssp_ctrl_one

/* sim/ssp_ctrl_one_sva.sv */
// assertion checker for the serial port control-one block
`timescale 1ns/1ps
module ssp_ctrl_one_chk
    import ssp_ctrl_pkg::*;
(
    // clock and reset
    input wire logic                           core_clk,
    input wire logic                           rst_b,
    // register bus
    input wire logic [ssp_ctrl_pkg::ADDR_W-1:0] address,
    input wire logic                           read,
    input wire logic                           write,
    input wire logic [ssp_ctrl_pkg::DATA_W-1:0] writedata,
    input wire logic [ssp_ctrl_pkg::DATA_W-1:0] readdata,
    input wire logic                           waitrequest,
    // pins
    input wire logic [ssp_ctrl_pkg::PIN_N-1:0]  pinOut,
    input wire logic [ssp_ctrl_pkg::PIN_N-1:0]  pinOe,
    input wire logic [ssp_ctrl_pkg::PIN_N-1:0]  gpioOut,
    input wire logic [ssp_ctrl_pkg::PIN_N-1:0]  gpioOe
);
    logic [7:0] ctrl;
    logic [1:0] ctrlAge;
    logic       ctrlWr;
    logic       spiMaster;
    logic       i2cSlave;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // decode of the shadowed mode field
    assign ctrlWr    = write && !waitrequest && address == ADDR_CONTROL_ONE;
    assign spiMaster = ctrl[3:0] inside {SEL_SPI_MASTER_DIV4, SEL_SPI_MASTER_DIV16, SEL_SPI_MASTER_DIV64,
                                         SEL_SPI_MASTER_TIMER, SEL_SPI_MASTER_BAUD};
    assign i2cSlave  = ctrl[3:0] inside {SEL_I2C_SLAVE_7BIT, SEL_I2C_SLAVE_10BIT};
    // shadow of control writes; age lets registered pins settle before judging
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl    <= 8'h00;
            ctrlAge <= 2'h0;
        end else if (ctrlWr) begin
            ctrl    <= writedata[7:0];
            ctrlAge <= 2'h0;
        end else if (ctrlAge != 2'h3) begin
            ctrlAge <= ctrlAge + 2'h1;
        end
    end
    sequence s_take; (read || write) && waitrequest; endsequence
    sequence s_ack; !waitrequest ##1 waitrequest; endsequence
    chk_answer_after_take: assert property (s_take |=> s_ack)
        else $error("bus answer not one wait state");
    chk_no_stray_ack: assert property (!waitrequest |-> (read || write))
        else $error("waitrequest low without request");
    chk_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (read && !waitrequest && address == ADDR_CONTROL_ONE
        |-> readdata[5:0] == ctrl[5:0]) else $error("control readback differs");
    chk_gpio_passthru: assert property (ctrlAge == 2'h3 && !ctrl[5]
        |-> pinOut == $past(gpioOut) && pinOe == $past(gpioOe)) else $error("gpio not passed to pins");
    chk_spi_clk_drive: assert property (ctrlAge == 2'h3 && ctrl[5] && spiMaster
        |-> pinOe[PIN_CLOCK]) else $error("spi master clock pin not driven");
    chk_i2c_scl_stretch: assert property (ctrlAge == 2'h3 && ctrl[5] && i2cSlave
        |-> pinOe[PIN_CLOCK] == !ctrl[4] && !pinOut[PIN_CLOCK]) else $error("scl stretch wrong");
endmodule : ssp_ctrl_one_chk

bind ssp_ctrl_one ssp_ctrl_one_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pinOut(pinOut),
    .pinOe(pinOe), .gpioOut(gpioOut), .gpioOe(gpioOe));

/* sim/spi_master_model.sv */
// far-side serial master model that drives the link
`timescale 1ns/1ps
module spi_master_model (
    // link outputs
    output logic linkClk,
    output logic linkSelN,
    output logic linkData
);
    // idle: clock parked, not selected
    initial begin
        linkClk  = 1'b0;
        linkSelN = 1'b1;
        linkData = 1'b1;
    end
    // one frame msb first; clock stands still between frames
    task automatic send_byte(input logic [7:0] b);
        #13 linkSelN = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            linkData = b[i];
            #40 linkClk = 1'b1;
            #40 linkClk = 1'b0;
        end
        #40 linkSelN = 1'b1;
        linkData = ~linkData; // released line must not show a stale bit
    endtask : send_byte
endmodule : spi_master_model

/* sim/tb_top.sv */
// self-checking bench for the serial port control-one block
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import ssp_ctrl_pkg::*;
    logic              core_clk  = 1'b0;
    logic              rst_b     = 1'b0;
    logic [ADDR_W-1:0] address   = 4'h0;
    logic              read      = 1'b0;
    logic              write     = 1'b0;
    logic [DATA_W-1:0] writedata = 32'h0;
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic              linkClk;
    logic              linkSelN;
    logic              linkData;
    logic [PIN_N-1:0]  pinOut;
    logic [PIN_N-1:0]  pinOe;
    logic [PIN_N-1:0]  gpioIn;
    logic [PIN_N-1:0]  pinIn     = 4'h0;
    logic [PIN_N-1:0]  gpioOut   = 4'ha;
    logic [PIN_N-1:0]  gpioOe    = 4'h5;
    logic [DATA_W-1:0] rd;
    logic [3:0]        mstSel [5] = '{SEL_SPI_MASTER_DIV4, SEL_SPI_MASTER_DIV16, SEL_SPI_MASTER_DIV64,
                                      SEL_SPI_MASTER_TIMER, SEL_SPI_MASTER_BAUD};
    logic [3:0]        slvSel [4] = '{SEL_SPI_SLAVE_SELECT, SEL_SPI_SLAVE_NOSEL, SEL_I2C_SLAVE_7BIT,
                                      SEL_I2C_SLAVE_10BIT};
    int                miscompares = 0;
    int                checksDone  = 0;
    int                cycles      = 0;
    always #2.5 core_clk = ~core_clk;
    ssp_ctrl_one dut (.core_clk(core_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .linkClk(linkClk),
        .linkSelN(linkSelN), .linkData(linkData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn));
    spi_master_model link (.linkClk(linkClk), .linkSelN(linkSelN), .linkData(linkData));
    // avalon write: hold until waitrequest is sampled low
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        address   <= a;
        writedata <= {24'h0, d};
        write     <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_write
    // avalon read and compare
    task automatic expect_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        address <= a;
        read    <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        `CHK(rd, {24'h0, e})
    endtask : expect_reg
    // one link byte, then time for the crossing to land
    task automatic send(input logic [7:0] b);
        link.send_byte(b);
        repeat (8) @(posedge core_clk);
    endtask : send
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // hang guard, far above the few thousand cycles needed
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        expect_reg(ADDR_CONTROL_ONE, 8'h00);
        expect_reg(ADDR_STATUS, 8'h00);
        expect_reg(4'h2, 8'h00);
        `CHK(pinOut, 4'ha)
        `CHK(pinOe, 4'h5)
        bus_write(ADDR_CONTROL_ONE, 8'h34);
        expect_reg(ADDR_STATUS, 8'h04);
        `CHK(pinOe[PIN_DOUT], 1'b1)
        // slave data out is released while the select pin is high
        pinIn <= 4'h8;
        repeat (4) @(posedge core_clk);
        `CHK(pinOe[PIN_DOUT], 1'b0)
        pinIn <= 4'h0;
        repeat (4) @(posedge core_clk);
        send(8'ha5);
        expect_reg(ADDR_STATUS, 8'h05);
        expect_reg(ADDR_BUFFER, 8'ha5);
        send(8'h5a);
        expect_reg(ADDR_BUFFER, 8'h5a);
        expect_reg(ADDR_CONTROL_ONE, 8'h34);
        // slave modes: second unread byte overflows and the flag sticks
        foreach (slvSel[i]) begin
            bus_write(ADDR_CONTROL_ONE, {4'h2, slvSel[i]});
            send(8'h3c);
            send(8'hc3);
            expect_reg(ADDR_CONTROL_ONE, {4'h6, slvSel[i]});
            expect_reg(ADDR_BUFFER, 8'h3c);
            expect_reg(ADDR_CONTROL_ONE, {4'h6, slvSel[i]});
            bus_write(ADDR_CONTROL_ONE, {4'h2, slvSel[i]});
            expect_reg(ADDR_CONTROL_ONE, {4'h2, slvSel[i]});
        end
        // I2C transmit direction: overflow flag is not raised
        bus_write(ADDR_AUX_CONTROL, 8'h01);
        send(8'h3c);
        send(8'hc3);
        expect_reg(ADDR_CONTROL_ONE, {4'h2, SEL_I2C_SLAVE_10BIT});
        expect_reg(ADDR_BUFFER, 8'h3c);
        expect_reg(ADDR_AUX_CONTROL, 8'h01);
        bus_write(ADDR_AUX_CONTROL, 8'h00);
        // SPI master modes never overflow
        foreach (mstSel[i]) begin
            bus_write(ADDR_CONTROL_ONE, {4'h2, mstSel[i]});
            send(8'h11);
            send(8'h22);
            expect_reg(ADDR_CONTROL_ONE, {4'h2, mstSel[i]});
            expect_reg(ADDR_STATUS, 8'h05);
            expect_reg(ADDR_BUFFER, 8'h11);
        end
        bus_write(ADDR_CONTROL_ONE, 8'h30);
        repeat (4) @(posedge core_clk);
        `CHK(pinOut[PIN_CLOCK], 1'b1)
        bus_write(ADDR_CONTROL_ONE, 8'h20);
        repeat (4) @(posedge core_clk);
        `CHK(pinOut[PIN_CLOCK], 1'b0)
        bus_write(ADDR_CONTROL_ONE, 8'h26);
        repeat (4) @(posedge core_clk);
        `CHK(pinOe[PIN_CLOCK], 1'b1)
        `CHK(pinOut[PIN_CLOCK], 1'b0)
        bus_write(ADDR_CONTROL_ONE, 8'h36);
        repeat (4) @(posedge core_clk);
        `CHK(pinOe[PIN_CLOCK], 1'b0)
        // second buffer write before the byte goes out collides and is refused
        bus_write(ADDR_CONTROL_ONE, 8'h20);
        bus_write(ADDR_BUFFER, 8'h81);
        expect_reg(ADDR_STATUS, 8'h06);
        bus_write(ADDR_BUFFER, 8'h42);
        expect_reg(ADDR_CONTROL_ONE, 8'ha0);
        expect_reg(ADDR_BUFFER, 8'h81);
        send(8'h99);
        expect_reg(ADDR_STATUS, 8'h05);
        // buffer write while disabled in master mode collides
        bus_write(ADDR_CONTROL_ONE, 8'h00);
        bus_write(ADDR_BUFFER, 8'h77);
        expect_reg(ADDR_CONTROL_ONE, 8'h80);
        bus_write(ADDR_CONTROL_ONE, 8'h00);
        expect_reg(ADDR_CONTROL_ONE, 8'h00);
        gpioOut <= 4'h3;
        gpioOe  <= 4'hc;
        pinIn   <= 4'h6;
        repeat (4) @(posedge core_clk);
        `CHK(pinOut, 4'h3)
        `CHK(pinOe, 4'hc)
        `CHK(gpioIn, 4'h6)
        stop_test();
    end
endmodule : tb_top
